// File: hdl/serializer_mode_config_regs.sv
// general configuration low bits and forward channel mode select registers
// assumes an i2c slave engine giving byte-wide read and write strobes
`timescale 1ns/1ps
`default_nettype none
module serializer_mode_config_regs (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] mode_strap_in,
  input wire logic address_strap_pin_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic crc_tx_enable_out,
  output logic i2c_level_1v8_out,
  output logic [2:0] mode_out,
  output logic mode_latched_out,
  output logic csi_sync_mode_out,
  output logic csi_ext_clk_mode_out,
  output logic csi_always_on_clk_mode_out,
  output logic parallel_video_mode_out
);
  import mode_cfg_pkg::*;

  logic crc_en_q;
  logic lvl_q;
  logic ov_q;
  logic [2:0] mode_reg_q;
  logic [7:0] rdata_q;
  logic [2:0] mode_q;
  logic sync_q, ext_q, on_q, par_q;
  logic [2:0] strap_mode;
  logic strap_level;
  logic capture;
  logic latched;

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  mode_strap_latch u_latch (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .mode_strap_in(mode_strap_in),
    .address_strap_pin_in(address_strap_pin_in),
    .strap_mode_out(strap_mode),
    .strap_level_out(strap_level),
    .capture_out(capture),
    .latched_out(latched)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic gen_wr = reg_wr_in && (reg_addr_in == GEN_CFG_ADDR);
  wire logic mode_wr = reg_wr_in && (reg_addr_in == MODE_SELECT_ADDR);
  wire logic mode_field_wr = mode_wr && ov_q;
  wire logic [2:0] mode_eff = ov_q ? mode_reg_q : strap_mode;
  wire logic [7:0] gen_rd = {6'h00, crc_en_q, lvl_q};
  wire logic [7:0] mode_rd = {3'h0, ov_q, latched, mode_eff};
  wire logic [7:0] rd_mux = (reg_addr_in == GEN_CFG_ADDR) ? gen_rd :
                            (reg_addr_in == MODE_SELECT_ADDR) ? mode_rd : 8'h00;
  wire logic [7:0] rdata_d = reg_rd_in ? rd_mux : rdata_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc_en_q <= CRC_EN_RESET;
      lvl_q <= 1'b0;
      ov_q <= MODE_OVERRIDE_RESET;
      mode_reg_q <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      if (gen_wr) crc_en_q <= reg_wdata_in[CRC_EN_BIT];
      if (capture) lvl_q <= strap_level;
      else if (gen_wr) lvl_q <= reg_wdata_in[I2C_LVL_BIT];
      if (mode_wr) ov_q <= reg_wdata_in[MODE_OVERRIDE_BIT];
      if (capture) mode_reg_q <= strap_mode;
      else if (mode_field_wr) mode_reg_q <= reg_wdata_in[MODE_MSB:0];
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= 3'h0;
      sync_q <= 1'b0;
      ext_q <= 1'b0;
      on_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      mode_q <= mode_eff;
      sync_q <= latched && (mode_eff == MODE_CSI_SYNC);
      ext_q <= latched && (mode_eff == MODE_CSI_EXT_CLK);
      on_q <= latched && (mode_eff == MODE_CSI_ALWAYS_ON_CLK);
      par_q <= latched && (mode_eff == MODE_PAR_VIDEO);
    end
  end

  assign reg_rdata_out = rdata_q;
  assign crc_tx_enable_out = crc_en_q;
  assign i2c_level_1v8_out = lvl_q;
  assign mode_out = mode_q;
  assign mode_latched_out = latched;
  assign csi_sync_mode_out = sync_q;
  assign csi_ext_clk_mode_out = ext_q;
  assign csi_always_on_clk_mode_out = on_q;
  assign parallel_video_mode_out = par_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // ------------------------------------------------------------
  // check helpers
  // ------------------------------------------------------------
  logic [2:0] since_release_q;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      since_release_q <= 3'h0;
    end else if (since_release_q != 3'h7) begin
      since_release_q <= since_release_q + 3'h1;
    end
  end

  sequence gen_write_s;
    reg_wr_in && reg_addr_in == GEN_CFG_ADDR && !capture;
  endsequence
  sequence gen_read_s;
    reg_rd_in && reg_addr_in == GEN_CFG_ADDR;
  endsequence
  sequence mode_write_s;
    reg_wr_in && reg_addr_in == MODE_SELECT_ADDR;
  endsequence
  sequence mode_read_s;
    reg_rd_in && reg_addr_in == MODE_SELECT_ADDR;
  endsequence
  sequence mode_write_locked_s;
    reg_wr_in && reg_addr_in == MODE_SELECT_ADDR && !ov_q && !capture;
  endsequence
  sequence mode_write_open_s;
    reg_wr_in && reg_addr_in == MODE_SELECT_ADDR && ov_q && !capture;
  endsequence
  sequence release_settle_s;
    since_release_q == MODE_SETTLE_CYCLES;
  endsequence

  crc_enable_a: assert property (gen_write_s |=> crc_tx_enable_out == $past(reg_wdata_in[CRC_EN_BIT]))
    else $error("crc enable did not follow write");
  gen_readback_a: assert property (gen_read_s |=> reg_rdata_out[CRC_EN_BIT] == $past(crc_tx_enable_out))
    else $error("crc enable readback wrong");
  level_strap_a: assert property (capture |=> i2c_level_1v8_out == $past(strap_level))
    else $error("voltage level not loaded from strap");
  level_write_a: assert property (gen_write_s |=> i2c_level_1v8_out == $past(reg_wdata_in[I2C_LVL_BIT]))
    else $error("voltage level did not follow write");
  level_readback_a: assert property (gen_read_s |=> reg_rdata_out[I2C_LVL_BIT] == $past(i2c_level_1v8_out))
    else $error("voltage level readback wrong");
  mode_select_a: assert property (##1 mode_out == ($past(ov_q) ? $past(mode_reg_q) : $past(strap_mode)))
    else $error("mode output not from selected source");
  override_write_a: assert property (mode_write_s |=> ov_q == $past(reg_wdata_in[MODE_OVERRIDE_BIT]))
    else $error("override bit did not follow write");
  override_readback_a: assert property (
    mode_read_s |=> reg_rdata_out[MODE_OVERRIDE_BIT] == $past(ov_q))
    else $error("override bit readback wrong");
  done_readback_a: assert property (
    mode_read_s |=> reg_rdata_out[MODE_DONE_BIT] == $past(latched))
    else $error("mode latched bit readback wrong");
  reserved_zero_a: assert property (
    mode_read_s |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved mode bits read nonzero");
  field_readback_a: assert property (
    mode_read_s |=> reg_rdata_out[MODE_MSB:0] == ($past(ov_q) ? $past(mode_reg_q) : $past(strap_mode)))
    else $error("mode field readback not the mode in effect");
  field_locked_a: assert property (mode_write_locked_s |=> $stable(mode_reg_q))
    else $error("mode field took write while not overridden");
  field_open_a: assert property (mode_write_open_s |=> mode_reg_q == $past(reg_wdata_in[MODE_MSB:0]))
    else $error("mode field ignored write while overridden");
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  strap_capture_a: assert property (capture |=> mode_reg_q == $past(strap_mode) ##0 latched)
    else $error("strapped mode not captured");
  capture_once_a: assert property (capture |=> !capture [*8])
    else $error("strap captured twice after one release");
  decode_sync_a: assert property (
    latched && mode_eff == MODE_CSI_SYNC |=> csi_sync_mode_out && !csi_ext_clk_mode_out)
    else $error("synchronous csi mode decode wrong");
  decode_ext_a: assert property (
    latched && mode_eff == MODE_CSI_EXT_CLK |=> csi_ext_clk_mode_out && !csi_sync_mode_out)
    else $error("external clock csi mode decode wrong");
  decode_on_a: assert property (
    latched && mode_eff == MODE_CSI_ALWAYS_ON_CLK |=> csi_always_on_clk_mode_out && !parallel_video_mode_out)
    else $error("always-on clock csi mode decode wrong");
  decode_reserved_a: assert property (
    mode_eff == MODE_RESERVED |=> !csi_sync_mode_out && !csi_ext_clk_mode_out && !csi_always_on_clk_mode_out
      && !parallel_video_mode_out)
    else $error("reserved mode code decoded as a mode");
  decode_onehot_a: assert property (
    $onehot0({csi_sync_mode_out, csi_ext_clk_mode_out, csi_always_on_clk_mode_out, parallel_video_mode_out}))
    else $error("more than one mode decode active");
  decode_par_a: assert property (
    latched && mode_eff == MODE_PAR_VIDEO |=> parallel_video_mode_out && !csi_always_on_clk_mode_out)
    else $error("parallel video mode decode wrong");
  decode_idle_a: assert property (
    !latched |=> !csi_sync_mode_out && !csi_ext_clk_mode_out && !csi_always_on_clk_mode_out
      && !parallel_video_mode_out)
    else $error("mode decode active before the mode latched");
  latched_hold_a: assert property (latched |=> latched [*8])
    else $error("mode latched bit dropped");
  latched_late_a: assert property ($rose(latched) |-> capture && !$past(latched))
    else $error("mode latched rose without capture");
  latched_early_a: assert property (since_release_q < MODE_SETTLE_CYCLES |-> !latched)
    else $error("mode latched bit set before the settle time");
  latched_due_a: assert property (release_settle_s |-> latched && capture)
    else $error("mode latched bit late after release");
endmodule
`default_nettype wire

// File: hdl/mode_cfg_pkg.sv
// constants for the serializer mode and general configuration register bank
// assumes a 10 MHz register clock and an i2c engine that presents byte accesses
package mode_cfg_pkg;

  // ------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] GEN_CFG_ADDR = 8'h02;
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h03;
  localparam int CRC_EN_BIT = 1;
  localparam int I2C_LVL_BIT = 0;
  localparam int MODE_OVERRIDE_BIT = 4;
  localparam int MODE_DONE_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam logic CRC_EN_RESET = 1'b1;
  localparam logic MODE_OVERRIDE_RESET = 1'b0;

  // ------------------------------------------------------------
  // mode codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_CSI_SYNC = 3'h0;
  localparam logic [2:0] MODE_RESERVED = 3'h1;
  localparam logic [2:0] MODE_CSI_EXT_CLK = 3'h2;
  localparam logic [2:0] MODE_CSI_ALWAYS_ON_CLK = 3'h3;
  localparam logic [2:0] MODE_PAR_VIDEO = 3'h5;

  // ------------------------------------------------------------
  // strap settle timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MODE_SETTLE_NS = 400;
  localparam logic [2:0] MODE_SETTLE_CYCLES =
    3'((MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    LATCH_WAIT = 2'b01,
    LATCH_DONE = 2'b10
  } latch_state_t;

endpackage

// File: hdl/mode_strap_latch.sv
// strap capture after power-down release
// assumes straps are stable and synchronous to the register clock
`timescale 1ns/1ps
`default_nettype none
module mode_strap_latch (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] mode_strap_in,
  input wire logic address_strap_pin_in,
  output logic [2:0] strap_mode_out,
  output logic strap_level_out,
  output logic capture_out,
  output logic latched_out
);
  import mode_cfg_pkg::*;

  latch_state_t state_q;
  logic [2:0] cnt_q;
  wire logic settle_end = (cnt_q == MODE_SETTLE_CYCLES - 3'h1);

  // ------------------------------------------------------------
  // settle counter then one capture
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= LATCH_WAIT;
      cnt_q <= 3'h0;
      capture_out <= 1'b0;
      latched_out <= 1'b0;
      strap_mode_out <= 3'h0;
      strap_level_out <= 1'b0;
    end else begin
      capture_out <= 1'b0;
      case (state_q)
        LATCH_WAIT: begin
          if (settle_end) begin
            state_q <= LATCH_DONE;
            strap_mode_out <= mode_strap_in;
            strap_level_out <= address_strap_pin_in;
            capture_out <= 1'b1;
            latched_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        LATCH_DONE: begin
          state_q <= LATCH_DONE;
        end
        default: begin
          state_q <= LATCH_WAIT;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/reg_host_model.sv
// register host model: byte strobes as the i2c engine presents them
// assumes one bench process calls its tasks
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end
  // one write strobe; level bit meant to be set remotely
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_serializer_mode_config_regs.sv
// testbench for the mode and general configuration register bank
// assumes the host model drives the byte strobes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module tb_serializer_mode_config_regs;
  import mode_cfg_pkg::*;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [2:0] strap = 3'h0;
  logic strap_a = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, crc, lvl, latched, sync_m, ext_m, always_on_m, par_m;
  logic [2:0] mode;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h1};
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  reg_host_model host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd));
  serializer_mode_config_regs uut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .mode_strap_in(strap), .address_strap_pin_in(strap_a), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .crc_tx_enable_out(crc), .i2c_level_1v8_out(lvl), .mode_out(mode),
    .mode_latched_out(latched), .csi_sync_mode_out(sync_m),
    .csi_ext_clk_mode_out(ext_m), .csi_always_on_clk_mode_out(always_on_m),
    .parallel_video_mode_out(par_m));
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic startup(input logic [2:0] m, input logic a);
    arst_n_in = 1'b0;
    strap = m;
    strap_a = a;
    repeat (2) @(posedge mclk_in);
    `CHK(crc, 1'b1)
    #1;
    arst_n_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK(latched, 1'b0)
    @(posedge mclk_in);
    #1;
    `CHK(latched, 1'b1)
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK(mode, m)
    `CHK(lvl, a)
    host.rd(MODE_SELECT_ADDR, d);
    `CHK(d, {3'h0, 1'b0, 1'b1, m})
  endtask
  task automatic gen_cfg();
    host.wr(GEN_CFG_ADDR, 8'h00);
    host.rd(GEN_CFG_ADDR, d);
    `CHK(d, 8'h00)
    `CHK({crc, lvl}, 2'b00)
    host.wr(GEN_CFG_ADDR, 8'hff);
    host.rd(GEN_CFG_ADDR, d);
    `CHK(d, 8'h03)
    `CHK({crc, lvl}, 2'b11)
    host.rd(8'h40, d);
    `CHK(d, 8'h00)
  endtask
  task automatic mode_sel(input logic [2:0] m);
    host.wr(MODE_SELECT_ADDR, {5'h0, ~m});
    host.wr(MODE_SELECT_ADDR, {5'h2, ~m});
    @(posedge mclk_in);
    #1;
    `CHK(mode, m)
    for (int i = 0; i < 5; i++) begin
      host.wr(MODE_SELECT_ADDR, {5'h2, codes[i]});
      @(posedge mclk_in);
      #1;
      `CHK(mode, codes[i])
      `CHK({sync_m, ext_m, always_on_m}, {codes[i] == 3'h0, codes[i] == 3'h2, codes[i] == 3'h3})
      `CHK(par_m, codes[i] == 3'h5)
      host.rd(MODE_SELECT_ADDR, d);
      `CHK(d, {5'h3, codes[i]})
    end
    host.wr(MODE_SELECT_ADDR, 8'h00);
    @(posedge mclk_in);
    #1;
    `CHK(mode, m)
  endtask
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    startup(3'h2, 1'b1);
    `CHK(ext_m, 1'b1)
    gen_cfg();
    mode_sel(3'h2);
    startup(3'h5, 1'b0);
    `CHK(par_m, 1'b1)
    mode_sel(3'h5);
    wrap_up();
  end
endmodule
`default_nettype wire
